// file: shared/pwm_cond_pkg.sv
// Constants, register map and field layout for the PWM output conditioning block
package pwm_cond_pkg;
  localparam int unsigned clk_period_ps = 5000;
  localparam int unsigned blank_max_ns = 4096;
  localparam int unsigned blank_max_cycles = (blank_max_ns * 1000) / clk_period_ps;
  // Register byte offsets
  localparam logic [4:0] off_blank_ctrl = 5'h00;
  localparam logic [4:0] off_blank_delay = 5'h04;
  localparam logic [4:0] off_aux_ctrl = 5'h08;
  localparam logic [4:0] off_gen_ctrl = 5'h0c;
  localparam logic [4:0] off_out_ctrl = 5'h10;
  localparam logic [4:0] off_chop = 5'h14;
  localparam logic [4:0] off_clk_div = 5'h18;
  localparam logic [4:0] off_capture = 5'h1c;
  // blank_control_reg fields
  localparam int unsigned b_high_rise = 15;
  localparam int unsigned b_high_fall = 14;
  localparam int unsigned b_low_rise = 13;
  localparam int unsigned b_low_fall = 12;
  localparam int unsigned b_fault_en = 11;
  localparam int unsigned b_limit_en = 10;
  localparam int unsigned b_chop_hi_st = 5;
  localparam int unsigned b_chop_lo_st = 4;
  localparam int unsigned b_hi_hi_st = 3;
  localparam int unsigned b_hi_lo_st = 2;
  localparam int unsigned b_lo_hi_st = 1;
  localparam int unsigned b_lo_lo_st = 0;
  // blank_delay_reg field 11:3
  localparam int unsigned delay_lsb = 3;
  localparam int unsigned delay_msb = 11;
  // aux_control_reg fields
  localparam int unsigned blank_src_lsb = 8;
  localparam int unsigned chop_src_lsb = 4;
  localparam int unsigned b_gate_high = 1;
  localparam int unsigned b_gate_low = 0;
  // gen_control_reg: deadtime_comp_mode 1:0
  localparam logic [1:0] comp_mode_on = 2'h1;
  // output_control_reg fields
  localparam int unsigned b_swap = 1;
  localparam int unsigned b_override_sync = 0;
  // chop register: enable bit 15, value 9:0
  localparam int unsigned b_chop_en = 15;
  localparam int unsigned chop_w = 10;
  localparam int unsigned gens = 16;
endpackage : pwm_cond_pkg

// file: hdl/pwm_output_conditioning.sv
// PWM output conditioning: blanking, compensation, chop, capture and swap
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pwm_output_conditioning import pwm_cond_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Raw PWM from generator core
  input wire logic gen_high,
  input wire logic gen_low,
  input wire logic [15:0] gen_duty,
  input wire logic [15:0] deadtime_value,
  input wire logic [15:0] alt_deadtime,
  input wire logic [15:0] itb_count,
  input wire logic timebase_zero,
  // Other generators and external pins
  input wire logic [gens-1:0] peer_high,
  input wire logic [gens-1:0] peer_low,
  input wire logic fault_pin,
  input wire logic limit_pin,
  input wire logic deadtime_comp_input,
  // Conditioned outputs
  output logic [15:0] active_duty,
  output logic [15:0] deadtime_used,
  output logic swapped_high,
  output logic swapped_low,
  output logic fault_active,
  output logic limit_active,
  output logic high_output,
  output logic low_output,
  output logic gate_clock_out
);

  function automatic logic sel_bit(input logic [gens-1:0] v, input logic [3:0] s);
    sel_bit = v[s];
  endfunction : sel_bit

  logic [15:0] blank_control_reg_r;
  logic [15:0] blank_delay_reg_r;
  logic [15:0] aux_control_reg_r;
  logic [15:0] gen_control_reg_r;
  logic [15:0] output_control_reg_r;
  logic [15:0] chop_reg_r;
  logic [2:0] pwm_clock_prescale_r;
  logic [15:0] timebase_capture_reg_r;
  logic rvalid_r;
  logic [31:0] rdata_r;

  // Pin synchronisers
  logic [1:0] fault_s_r, limit_s_r, comp_s_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fault_s_r <= 2'h0;
      limit_s_r <= 2'h0;
      comp_s_r <= 2'h0;
    end else begin
      fault_s_r <= {fault_s_r[0], fault_pin};
      limit_s_r <= {limit_s_r[0], limit_pin};
      comp_s_r <= {comp_s_r[0], deadtime_comp_input};
    end
  end
  wire fault_sync = fault_s_r[1];
  wire limit_sync = limit_s_r[1];
  wire comp_sync = comp_s_r[1];

  // Register bus: writes take effect at once, reads answer one cycle later
  wire wr = avs_write;
  wire rd_hit = avs_read && !rvalid_r;
  assign avs_waitrequest = avs_read && !rvalid_r;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // Prescaled PWM clock enable
  logic [7:0] pre_cnt_r;
  wire [7:0] pre_top = 8'((9'h1 << pwm_clock_prescale_r) - 9'h1);
  wire pwm_tick = (pre_cnt_r >= pre_top);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) pre_cnt_r <= 8'h0;
    else pre_cnt_r <= pwm_tick ? 8'h0 : pre_cnt_r + 8'h1;
  end

  // Chop generator, toggles every chop value plus one ticks
  logic [chop_w-1:0] chop_cnt_r;
  logic chop_gen_r;
  wire chop_en = chop_reg_r[b_chop_en];
  wire [chop_w-1:0] chop_val = chop_reg_r[chop_w-1:0];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      chop_cnt_r <= '0;
      chop_gen_r <= 1'b0;
    end else if (!chop_en) begin
      chop_cnt_r <= '0;
      chop_gen_r <= 1'b0;
    end else if (pwm_tick) begin
      if (chop_cnt_r >= chop_val) begin
        chop_cnt_r <= '0;
        chop_gen_r <= ~chop_gen_r;
      end else begin
        chop_cnt_r <= chop_cnt_r + 1'b1;
      end
    end
  end

  // Source zero is internal generator, others pick peer high outputs
  wire [3:0] chop_src = aux_control_reg_r[chop_src_lsb +: 4];
  wire chop_clk = (chop_src == 4'h0) ? chop_gen_r : sel_bit(peer_high, chop_src);
  assign gate_clock_out = chop_gen_r;

  // Swap, synchronised to time base zero when requested
  logic swap_r;
  wire swap_req = output_control_reg_r[b_swap];
  wire override_sync = output_control_reg_r[b_override_sync];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) swap_r <= 1'b0;
    else if (!override_sync || timebase_zero) swap_r <= swap_req;
  end
  // Swap before dead time, which is downstream
  assign swapped_high = swap_r ? gen_low : gen_high;
  assign swapped_low = swap_r ? gen_high : gen_low;

  // Edge blanking timer on the swapped signals
  logic prev_h_r, prev_l_r;
  logic [8:0] blank_cnt_r;
  logic blank_run_r;
  wire [8:0] blank_delay = blank_delay_reg_r[delay_msb:delay_lsb];
  wire edge_hit = (blank_control_reg_r[b_high_rise] && swapped_high && !prev_h_r) ||
                  (blank_control_reg_r[b_high_fall] && !swapped_high && prev_h_r) ||
                  (blank_control_reg_r[b_low_rise] && swapped_low && !prev_l_r) ||
                  (blank_control_reg_r[b_low_fall] && !swapped_low && prev_l_r);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prev_h_r <= 1'b0;
      prev_l_r <= 1'b0;
      blank_cnt_r <= 9'h0;
      blank_run_r <= 1'b0;
    end else begin
      prev_h_r <= swapped_high;
      prev_l_r <= swapped_low;
      if (edge_hit && blank_delay != 9'h0) begin
        blank_cnt_r <= 9'h0;
        blank_run_r <= 1'b1;
      end else if (blank_run_r && pwm_tick) begin
        if (blank_cnt_r + 9'h1 >= blank_delay) blank_run_r <= 1'b0;
        blank_cnt_r <= blank_cnt_r + 9'h1;
      end
    end
  end

  // State blanking from selected generator and from the chop clock
  wire [3:0] bsrc = aux_control_reg_r[blank_src_lsb +: 4];
  wire st_h = sel_bit(peer_high, bsrc);
  wire st_l = sel_bit(peer_low, bsrc);
  wire state_blank = (blank_control_reg_r[b_hi_hi_st] && st_h) || (blank_control_reg_r[b_hi_lo_st] && !st_h) ||
                     (blank_control_reg_r[b_lo_hi_st] && st_l) || (blank_control_reg_r[b_lo_lo_st] && !st_l) ||
                     (blank_control_reg_r[b_chop_hi_st] && chop_clk) ||
                     (blank_control_reg_r[b_chop_lo_st] && !chop_clk);
  wire fault_blanked = (blank_run_r && blank_control_reg_r[b_fault_en]) || state_blank;
  wire limit_blanked = (blank_run_r && blank_control_reg_r[b_limit_en]) || state_blank;
  assign fault_active = fault_sync && !fault_blanked;
  assign limit_active = limit_sync && !limit_blanked;

  // Capture of primary independent time base only
  logic limit_prev_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) limit_prev_r <= 1'b0;
    else limit_prev_r <= limit_active;
  end
  wire capture_hit = limit_active && !limit_prev_r;

  // Dead-time compensation; caller keeps mode complementary and dead time positive
  wire comp_on = (gen_control_reg_r[1:0] == comp_mode_on);
  logic [15:0] duty_r, dt_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      duty_r <= 16'h0;
      dt_r <= 16'h0;
    end else begin
      duty_r <= !comp_on ? gen_duty : comp_sync ? gen_duty + deadtime_value : gen_duty - deadtime_value;
      dt_r <= comp_on ? alt_deadtime : deadtime_value;
    end
  end
  assign active_duty = duty_r;
  assign deadtime_used = dt_r;

  // Final gating after fault and limit override (applied in this block on the swapped signals)
  logic hi_q_r, lo_q_r;
  wire hi_fin = (fault_active || limit_active) ? 1'b0 : swapped_high;
  wire lo_fin = (fault_active || limit_active) ? 1'b0 : swapped_low;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hi_q_r <= 1'b0;
      lo_q_r <= 1'b0;
    end else begin
      hi_q_r <= aux_control_reg_r[b_gate_high] ? (hi_fin & chop_clk) : hi_fin;
      lo_q_r <= aux_control_reg_r[b_gate_low] ? (lo_fin & chop_clk) : lo_fin;
    end
  end
  assign high_output = hi_q_r;
  assign low_output = lo_q_r;

  // Register file
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      blank_control_reg_r <= 16'h0;
      blank_delay_reg_r <= 16'h0;
      aux_control_reg_r <= 16'h0;
      gen_control_reg_r <= 16'h0;
      output_control_reg_r <= 16'h0;
      chop_reg_r <= 16'h0;
      pwm_clock_prescale_r <= 3'h0;
      timebase_capture_reg_r <= 16'h0;
    end else begin
      if (capture_hit) timebase_capture_reg_r <= itb_count;
      if (wr) begin
        case (avs_address)
          off_blank_ctrl: blank_control_reg_r <= merge(blank_control_reg_r, avs_writedata, avs_byteenable);
          off_blank_delay: blank_delay_reg_r <= merge(blank_delay_reg_r, avs_writedata, avs_byteenable);
          off_aux_ctrl: aux_control_reg_r <= merge(aux_control_reg_r, avs_writedata, avs_byteenable);
          off_gen_ctrl: gen_control_reg_r <= merge(gen_control_reg_r, avs_writedata, avs_byteenable);
          off_out_ctrl: output_control_reg_r <= merge(output_control_reg_r, avs_writedata, avs_byteenable);
          off_chop: chop_reg_r <= merge(chop_reg_r, avs_writedata, avs_byteenable);
          off_clk_div: if (avs_byteenable[0]) pwm_clock_prescale_r <= avs_writedata[2:0];
          default: ;
        endcase
      end
    end
  end

  logic [15:0] rd_mux;
  always_comb begin
    case (avs_address)
      off_blank_ctrl: rd_mux = blank_control_reg_r;
      off_blank_delay: rd_mux = blank_delay_reg_r;
      off_aux_ctrl: rd_mux = aux_control_reg_r;
      off_gen_ctrl: rd_mux = gen_control_reg_r;
      off_out_ctrl: rd_mux = output_control_reg_r;
      off_chop: rd_mux = chop_reg_r;
      off_clk_div: rd_mux = {13'h0, pwm_clock_prescale_r};
      off_capture: rd_mux = timebase_capture_reg_r;
      default: rd_mux = 16'h0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      rvalid_r <= rd_hit;
      if (rd_hit) rdata_r <= {16'h0, rd_mux};
    end
  end
  assign avs_readdata = rdata_r;

endmodule : pwm_output_conditioning

// file: testbench/pwm_cond_checker.sv
// Port assertions for the PWM output conditioning block
`timescale 1ns/1ps
module pwm_cond_checker import pwm_cond_pkg::*; (
  // Clock, reset and bus
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Datapath
  input wire logic gen_high,
  input wire logic gen_low,
  input wire logic [15:0] gen_duty,
  input wire logic [15:0] deadtime_value,
  input wire logic [15:0] alt_deadtime,
  input wire logic [15:0] active_duty,
  input wire logic [15:0] deadtime_used,
  input wire logic swapped_high,
  input wire logic swapped_low,
  input wire logic fault_active,
  input wire logic limit_active,
  input wire logic high_output,
  input wire logic low_output
);
  // Shadow copies of mode bits, updated on the same edge as the block's own
  logic comp_r;
  logic gate_hi_r;
  wire wr_gen = avs_write && avs_address == off_gen_ctrl;
  wire wr_aux = avs_write && avs_address == off_aux_ctrl;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      comp_r <= 1'b0;
      gate_hi_r <= 1'b0;
    end else begin
      if (wr_gen) comp_r <= avs_writedata[1:0] == comp_mode_on;
      if (wr_aux) gate_hi_r <= avs_writedata[b_gate_high];
    end
  end
  // Held one edge past release, so no attempt starts on the release edge itself
  logic rst_hold_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) rst_hold_r <= 1'b1;
    else rst_hold_r <= 1'b0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || rst_hold_r);
  a_read_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait exceeds one cycle");
  a_write_fast: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_swap_pair: assert property ((swapped_high == gen_high && swapped_low == gen_low) ||
    (swapped_high == gen_low && swapped_low == gen_high)) else $error("swap output not a routing of the pair");
  a_force_low: assert property (fault_active || limit_active |=> !high_output && !low_output)
    else $error("outputs not forced low by fault or limit");
  a_pass_high: assert property (!gate_hi_r && !fault_active && !limit_active |=> high_output == $past(swapped_high))
    else $error("ungated high output differs from swapped signal");
  a_duty_comp: assert property (comp_r |=> active_duty == $past(gen_duty) + $past(deadtime_value) ||
    active_duty == $past(gen_duty) - $past(deadtime_value)) else $error("compensated duty wrong");
  a_duty_plain: assert property (!comp_r |=> active_duty == $past(gen_duty))
    else $error("plain duty wrong");
  a_dt_select: assert property (comp_r |=> deadtime_used == $past(alt_deadtime))
    else $error("alternate dead time not used");
  c_comp: cover property (comp_r && active_duty != gen_duty);
  c_swap: cover property (swapped_high != gen_high);
  c_chop: cover property (gate_hi_r && high_output);
endmodule : pwm_cond_checker

bind pwm_output_conditioning pwm_cond_checker i_pwm_cond_checker (.mclk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .gen_high, .gen_low, .gen_duty, .deadtime_value,
  .alt_deadtime, .active_duty, .deadtime_used, .swapped_high, .swapped_low, .fault_active, .limit_active,
  .high_output, .low_output);

// file: testbench/pwm_output_conditioning_tb_top.sv
// Self-checking bench for the PWM output conditioning block
`timescale 1ns/1ps
module pwm_output_conditioning_tb_top import pwm_cond_pkg::*;;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdata;
  logic avs_waitrequest, swapped_high, swapped_low, fault_active, limit_active, high_output, low_output;
  logic gen_high = 1'b0, gen_low = 1'b0, timebase_zero = 1'b0, fault_pin = 1'b0, limit_pin = 1'b0;
  logic deadtime_comp_input = 1'b0, gate_clock_out;
  logic [15:0] gen_duty = 16'h0064, deadtime_value = 16'h000a, alt_deadtime = 16'h0007, itb_count = 16'h1234;
  logic [15:0] active_duty, deadtime_used;
  logic [gens-1:0] peer_high = '0, peer_low = '0;
  int fails = 0;
  int checks_done = 0;
  int n, m;
  pwm_output_conditioning i_pwm_output_conditioning (.mclk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .gen_high, .gen_low, .gen_duty,
    .deadtime_value, .alt_deadtime, .itb_count, .timebase_zero, .peer_high, .peer_low, .fault_pin, .limit_pin,
    .deadtime_comp_input, .active_duty, .deadtime_used, .swapped_high, .swapped_low, .fault_active,
    .limit_active, .high_output, .low_output, .gate_clock_out);
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc
  // Both bus tasks return one edge after release, so strobes never retoggle in one step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
    chk(rdata, {16'h0000, exp});
  endtask : rd
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    fails++;
    finish_test();
  end
  initial begin
    cyc(6);
    reset <= 1'b0;
    cyc(1);
    wr(off_blank_ctrl, 16'hfc3f);
    rd(off_blank_ctrl, 16'hfc3f);
    wr(off_capture, 16'hffff);
    rd(off_capture, 16'h0000);
    $display("registers done");
    gen_high <= 1'b1;
    wr(off_out_ctrl, 16'h0002);
    @(negedge mclk);
    chk(swapped_low, 1'b1);
    // Pins are registered, so they follow one cycle behind the swap
    @(negedge mclk);
    chk(high_output, 1'b0);
    chk(low_output, 1'b1);
    @(posedge mclk);
    // Sync on: clearing the exchange must wait for the zero count
    wr(off_out_ctrl, 16'h0001);
    @(negedge mclk);
    chk(swapped_low, 1'b1);
    @(posedge mclk);
    timebase_zero <= 1'b1;
    @(posedge mclk);
    timebase_zero <= 1'b0;
    @(negedge mclk);
    chk(swapped_high, 1'b1);
    @(posedge mclk);
    $display("swap done");
    wr(off_gen_ctrl, {14'h0000, comp_mode_on});
    deadtime_comp_input <= 1'b1;
    cyc(5);
    @(negedge mclk);
    chk(active_duty, 16'h006e);
    chk(deadtime_used, 16'h0007);
    @(posedge mclk);
    deadtime_comp_input <= 1'b0;
    cyc(5);
    @(negedge mclk);
    chk(active_duty, 16'h005a);
    @(posedge mclk);
    wr(off_gen_ctrl, 16'h0000);
    @(negedge mclk);
    chk(deadtime_used, 16'h000a);
    @(posedge mclk);
    $display("compensation done");
    gen_high <= 1'b0;
    wr(off_blank_delay, 16'h00a0);
    wr(off_blank_ctrl, 16'h8400);
    fault_pin <= 1'b1;
    limit_pin <= 1'b1;
    cyc(4);
    gen_high <= 1'b1;
    cyc(5);
    gen_high <= 1'b0;
    cyc(5);
    // Second rise restarts the 20-tick window
    gen_high <= 1'b1;
    itb_count <= 16'h0042;
    cyc(14);
    @(negedge mclk);
    chk(limit_active, 1'b0);
    chk(fault_active, 1'b1);
    chk(high_output, 1'b0);
    cyc(14);
    @(negedge mclk);
    chk(limit_active, 1'b1);
    @(posedge mclk);
    rd(off_capture, 16'h0042);
    // State blanking follows generator 3, not this generator's own pair
    peer_high <= 16'h0008;
    wr(off_aux_ctrl, 16'h0300);
    wr(off_blank_ctrl, 16'h0408);
    @(negedge mclk);
    chk(limit_active, 1'b0);
    @(posedge mclk);
    peer_high <= 16'h0000;
    cyc(3);
    @(negedge mclk);
    chk(limit_active, 1'b1);
    @(posedge mclk);
    $display("blanking done");
    fault_pin <= 1'b0;
    limit_pin <= 1'b0;
    gen_high <= 1'b1;
    gen_low <= 1'b1;
    wr(off_chop, 16'h8001);
    rd(off_chop, 16'h8001);
    wr(off_aux_ctrl, 16'h0002);
    cyc(4);
    n = 0;
    m = 0;
    repeat (40) begin
      @(negedge mclk);
      n += gate_clock_out;
      m += high_output;
    end
    chk(n, 20);
    chk(m, 20);
    chk(low_output, 1'b1);
    @(posedge mclk);
    // Prescale by two halves the toggle rate of the chop generator
    wr(off_clk_div, 16'h0001);
    cyc(4);
    @(negedge mclk);
    m = gate_clock_out;
    n = 0;
    repeat (40) begin
      @(negedge mclk);
      n += (gate_clock_out != m);
      m = gate_clock_out;
    end
    chk(n, 10);
    @(posedge mclk);
    // Peer generator 1 as chop source, held high
    peer_high <= 16'h0002;
    wr(off_aux_ctrl, 16'h0012);
    cyc(2);
    m = 0;
    repeat (8) begin
      @(negedge mclk);
      m += high_output;
    end
    chk(m, 8);
    @(posedge mclk);
    wr(off_chop, 16'h0001);
    cyc(3);
    @(negedge mclk);
    chk(gate_clock_out, 1'b0);
    $display("chop done");
    finish_test();
  end
endmodule : pwm_output_conditioning_tb_top
